// ==== hw/dds_control_word_fields.sv ====
`timescale 1ns/10ps
module dds_control_word_fields
  import dds_ctrl_pkg::*;
#(
  parameter int FW = FREQ_W,
  parameter int PW = PHASE_W
)(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic frame_n,
  input wire logic freq_pick_pin,
  input wire logic phase_pick_pin,
  input wire logic reset_pin,
  input wire logic sleep_pin,
  input wire logic [FW-1:0] freq_word_a,
  input wire logic [FW-1:0] freq_word_b,
  input wire logic [PW-1:0] phase_offset_a,
  input wire logic [PW-1:0] phase_offset_b,
  input wire logic aux_data,
  output logic [PW-1:0] phase_out,
  output logic converter_on,
  output logic aux_out,
  output logic aux_oe,
  output logic [WORD_W-1:0] setup_word
);

  // Two-flop synchronisers for the serial and control pins; aux_data is registered once
  logic [1:0] sck_s_r, sdi_s_r, fsy_s_r, fp_s_r, pp_s_r, rp_s_r, sp_s_r;
  logic sck_d_r;
  always_ff @(posedge clock)
  begin
    sck_s_r <= {sck_s_r[0], serial_clk};
    sdi_s_r <= {sdi_s_r[0], serial_data};
    fsy_s_r <= {fsy_s_r[0], frame_n};
    fp_s_r <= {fp_s_r[0], freq_pick_pin};
    pp_s_r <= {pp_s_r[0], phase_pick_pin};
    rp_s_r <= {rp_s_r[0], reset_pin};
    sp_s_r <= {sp_s_r[0], sleep_pin};
    sck_d_r <= sck_s_r[1];
  end

  // Serial shift: data taken on falling serial clock while framed
  wire framed = ~fsy_s_r[1];
  wire sck_fall = sck_d_r & ~sck_s_r[1];
  logic [WORD_W-1:0] shift_r;
  logic [4:0] bitcnt_r;
  logic [WORD_W-1:0] setup_r;
  wire [WORD_W-1:0] shift_nxt = {shift_r[WORD_W-2:0], sdi_s_r[1]};
  wire word_done = framed & sck_fall & (bitcnt_r == 5'(WORD_W - 1));
  wire is_control = ~shift_nxt[POS_TAG_HI] & ~shift_nxt[POS_TAG_LO];
  always_ff @(posedge clock)
  begin
    if (!reset_n || !framed)
    begin
      bitcnt_r <= BITCNT_RESET;
      shift_r <= SETUP_RESET;
    end
    else if (sck_fall)
    begin
      shift_r <= shift_nxt;
      bitcnt_r <= word_done ? BITCNT_RESET : bitcnt_r + 5'h01;
    end
  end

  // Whole word committed at once
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      setup_r <= SETUP_RESET;
    else if (word_done && is_control)
      setup_r <= shift_nxt;
  end
  assign setup_word = setup_r;

  // Source selection between bits and pins
  wire pin_mode = setup_r[POS_SOURCE];
  wire freq_sel = pin_mode ? fp_s_r[1] : setup_r[POS_FREQ_PICK];
  wire phase_sel = pin_mode ? pp_s_r[1] : setup_r[POS_PHASE_PICK];
  wire core_rst = pin_mode ? rp_s_r[1] : setup_r[POS_RESET];
  wire pdown = pin_mode ? sp_s_r[1] : setup_r[POS_POWERDOWN];
  wire halt = setup_r[POS_HALT];
  wire [FW-1:0] tune = freq_sel ? freq_word_b : freq_word_a;
  wire [PW-1:0] poff = phase_sel ? phase_offset_b : phase_offset_a;

  // Internal falling edge: fields sampled once every two clocks as enable
  logic tick_r;
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      tick_r <= 1'b0;
    else
      tick_r <= ~tick_r;
  end

  // Tuning accumulator with reset and halt
  logic [FW-1:0] acc_r;
  logic [PW-1:0] phase_r;
  logic conv_r, aux_r, auxoe_r;
  always_ff @(posedge clock)
  begin
    if (!reset_n || core_rst)
    begin
      acc_r <= '0;
      phase_r <= '0;
    end
    else if (tick_r && !halt)
    begin
      acc_r <= acc_r + tune;
      phase_r <= acc_r[FW-1 -: PW] + poff;
    end
  end

  // Converter power and aux pin drive
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      conv_r <= 1'b0;
      auxoe_r <= 1'b0;
      aux_r <= 1'b0;
    end
    else
    begin
      conv_r <= ~pdown;
      auxoe_r <= setup_r[POS_AUX_EN];
      aux_r <= aux_data & setup_r[POS_AUX_EN];
    end
  end
  assign phase_out = phase_r;
  assign converter_on = conv_r;
  assign aux_out = aux_r;
  assign aux_oe = auxoe_r;

  // Commit and framing checks
  chk_commit_whole: assert property (@(posedge clock) disable iff (!reset_n)
    !(word_done && is_control) |=> setup_r == $past(setup_r)) else $error("setup changed mid word");
  chk_commit_load: assert property (@(posedge clock) disable iff (!reset_n)
    (word_done && is_control) |=> setup_r == $past(shift_nxt)) else $error("setup not loaded");
  chk_tag_refuse: assert property (@(posedge clock) disable iff (!reset_n)
    (word_done && !is_control) |=> setup_r == $past(setup_r)) else $error("untagged word taken");
  chk_frame_abort: assert property (@(posedge clock) disable iff (!reset_n)
    !framed |=> bitcnt_r == BITCNT_RESET) else $error("partial word kept");
  chk_count_range: assert property (@(posedge clock) disable iff (!reset_n)
    bitcnt_r <= 5'(WORD_W - 1)) else $error("bit count overrun");

  // Accumulator reset, halt and stepping
  chk_halt_freeze: assert property (@(posedge clock) disable iff (!reset_n)
    (halt && !core_rst) |=> acc_r == $past(acc_r)) else $error("accumulator moved in halt");
  chk_halt_hold: assert property (@(posedge clock) disable iff (!reset_n)
    (halt && !core_rst) |=> phase_out == $past(phase_out)) else $error("phase moved in halt");
  chk_reset_clear: assert property (@(posedge clock) disable iff (!reset_n)
    core_rst |=> acc_r == '0) else $error("reset did not clear");
  chk_reset_bit: assert property (@(posedge clock) disable iff (!reset_n)
    (!pin_mode && setup_r[POS_RESET])
    |=> (acc_r == '0) && (phase_out == '0)) else $error("reset bit ignored");
  chk_reset_pin: assert property (@(posedge clock) disable iff (!reset_n)
    (pin_mode && rp_s_r[1])
    |=> (acc_r == '0) && (phase_out == '0)) else $error("reset pin ignored");
  chk_reset_ignored: assert property (@(posedge clock) disable iff (!reset_n)
    (pin_mode && !rp_s_r[1] && setup_r[POS_RESET] && tick_r && !halt)
    |=> acc_r == $past(acc_r) + $past(tune)) else $error("reset bit taken in pin mode");
  chk_run_step: assert property (@(posedge clock) disable iff (!reset_n)
    (tick_r && !halt && !core_rst) |=> acc_r == $past(acc_r) + $past(tune)) else $error("no accumulate");
  chk_tick_toggle: assert property (@(posedge clock) disable iff (!reset_n)
    1'h1 |=> tick_r != $past(tick_r)) else $error("sampling enable stuck");

  // Bank selection into accumulator and phase adder
  chk_freq_source: assert property (@(posedge clock) disable iff (!reset_n)
    (tick_r && !halt && !core_rst && (pin_mode ? fp_s_r[1] : setup_r[POS_FREQ_PICK]))
    |=> acc_r == $past(acc_r) + $past(freq_word_b)) else $error("bad freq source");
  chk_freq_pick_a: assert property (@(posedge clock) disable iff (!reset_n)
    (tick_r && !halt && !core_rst && !(pin_mode ? fp_s_r[1] : setup_r[POS_FREQ_PICK]))
    |=> acc_r == $past(acc_r) + $past(freq_word_a)) else $error("word A not used");
  chk_phase_pick_b: assert property (@(posedge clock) disable iff (!reset_n)
    (tick_r && !halt && !core_rst && (pin_mode ? pp_s_r[1] : setup_r[POS_PHASE_PICK]))
    |=> phase_out == $past(acc_r[FW-1 -: PW]) + $past(phase_offset_b)) else $error("offset B not used");
  chk_phase_pick_a: assert property (@(posedge clock) disable iff (!reset_n)
    (tick_r && !halt && !core_rst && !(pin_mode ? pp_s_r[1] : setup_r[POS_PHASE_PICK]))
    |=> phase_out == $past(acc_r[FW-1 -: PW]) + $past(phase_offset_a)) else $error("offset A not used");

  // Converter power and aux pin
  chk_power_pin: assert property (@(posedge clock) disable iff (!reset_n)
    (pin_mode && sp_s_r[1]) |=> !converter_on) else $error("pin powerdown ignored");
  chk_power_ignore: assert property (@(posedge clock) disable iff (!reset_n)
    (pin_mode && !sp_s_r[1]) |=> converter_on) else $error("powerdown bit taken in pin mode");
  chk_power_bit: assert property (@(posedge clock) disable iff (!reset_n)
    (!pin_mode && !setup_r[POS_POWERDOWN]) |=> converter_on) else $error("converter off");
  chk_power_off_bit: assert property (@(posedge clock) disable iff (!reset_n)
    (!pin_mode && setup_r[POS_POWERDOWN]) |=> !converter_on) else $error("converter left on");
  chk_aux_drive: assert property (@(posedge clock) disable iff (!reset_n)
    setup_r[POS_AUX_EN] |=> aux_oe && (aux_out == $past(aux_data))) else $error("aux not driven");
  chk_aux_float: assert property (@(posedge clock) disable iff (!reset_n)
    !setup_r[POS_AUX_EN] |=> !aux_oe) else $error("aux driven");
  chk_aux_low: assert property (@(posedge clock) disable iff (!reset_n)
    !setup_r[POS_AUX_EN] |=> !aux_out) else $error("aux value leaked");

  // Main scenarios reached
  cov_word: cover property (@(posedge clock) word_done && is_control);
  cov_refused: cover property (@(posedge clock) word_done && !is_control);
  cov_halt: cover property (@(posedge clock) halt);
  cov_pin: cover property (@(posedge clock) pin_mode && fp_s_r[1]);
  cov_reset_bit: cover property (@(posedge clock) !pin_mode && setup_r[POS_RESET]);
endmodule : dds_control_word_fields

// ==== hw/dds_ctrl_pkg.sv ====
package dds_ctrl_pkg;
  // Control word layout
  localparam int WORD_W = 16;
  localparam int POS_TAG_HI = 15;
  localparam int POS_TAG_LO = 14;
  localparam int POS_FREQ_PICK = 11;
  localparam int POS_PHASE_PICK = 10;
  localparam int POS_SOURCE = 9;
  localparam int POS_RESET = 8;
  localparam int POS_HALT = 7;
  localparam int POS_POWERDOWN = 6;
  localparam int POS_AUX_EN = 5;
  // Reset state of the held control word (all fields clear)
  localparam logic [15:0] SETUP_RESET = 16'h0000;
  localparam logic [4:0] BITCNT_RESET = 5'h00;
  // Default accumulator widths
  localparam int FREQ_W = 28;
  localparam int PHASE_W = 12;
endpackage : dds_ctrl_pkg

// ==== tb/dds_host.sv ====
`timescale 1ns/10ps
// Host end of the serial link; serial clock idles high between frames
module dds_host (
  input wire logic clock,
  output logic serial_clk,
  output logic serial_data,
  output logic frame_n
);
  initial
  begin
    serial_clk = 1'b1;
    serial_data = 1'b0;
    frame_n = 1'b1;
  end
  // Sends one word MSB first; the caller supplies the 00 tag
  task automatic send(input logic [15:0] w);
    frame_n = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      serial_data = w[i];
      repeat (4) @(negedge clock);
      serial_clk = 1'b0;
      repeat (4) @(negedge clock);
      serial_clk = 1'b1;
    end
    repeat (4) @(negedge clock);
    frame_n = 1'b1;
    serial_data = ~serial_data; // Released line shows no stale value
    repeat (12) @(negedge clock);
  endtask : send
endmodule : dds_host

// ==== tb/tb_dds_control_word_fields.sv ====
`timescale 1ns/10ps
module tb_dds_control_word_fields;
  // Inputs start defined; pick pins held steady while bits rule
  logic clock = 1'b0, reset_n = 1'b0, aux_data = 1'b1;
  logic freq_pick_pin = 1'b0, phase_pick_pin = 1'b0, reset_pin = 1'b0, sleep_pin = 1'b0;
  logic [27:0] freq_word_a = 28'h0000000, freq_word_b = 28'h0100000;
  logic [11:0] phase_offset_a = 12'h123, phase_offset_b = 12'hABC, phase_out, held;
  logic serial_clk, serial_data, frame_n, converter_on, aux_out, aux_oe;
  logic [15:0] setup_word;
  int n_errors = 0;
  int compares = 0;
  always #50 clock = ~clock;
  dds_host i_host (.clock, .serial_clk, .serial_data, .frame_n);
  dds_control_word_fields i_dut (.clock, .reset_n, .serial_clk, .serial_data, .frame_n, .freq_pick_pin,
    .phase_pick_pin, .reset_pin, .sleep_pin, .freq_word_a, .freq_word_b, .phase_offset_a, .phase_offset_b,
    .aux_data, .phase_out, .converter_on, .aux_out, .aux_oe, .setup_word);
  // Counts and reports one comparison
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Whether the phase output moves over a few steps
  task automatic moved(input logic exp);
    held = phase_out;
    repeat (6) @(negedge clock);
    check(16'(phase_out !== held), 16'(exp));
  endtask : moved
  task automatic end_of_test;
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  // Main sequence of control words
  initial
  begin
    repeat (12) @(negedge clock);
    reset_n = 1'b1;
    repeat (4) @(negedge clock);
    check(setup_word, 16'h0000);
    check(16'(converter_on), 16'h0001);
    check(16'(phase_out), 16'(phase_offset_a));
    i_host.send(16'h0420);
    check(setup_word, 16'h0420);
    check(16'(phase_out), 16'(phase_offset_b));
    check(16'({aux_oe, aux_out}), 16'h0003);
    aux_data = 1'h0;
    repeat (2) @(negedge clock);
    check(16'({aux_oe, aux_out}), 16'h0002);
    i_host.send(16'h4000);
    check(setup_word, 16'h0420);
    aux_data = 1'h1;
    i_host.send(16'h0040);
    check(16'({converter_on, aux_oe, aux_out}), 16'h0000);
    i_host.send(16'h0640);
    check(16'({converter_on, phase_out}), 16'({1'h1, phase_offset_a}));
    phase_pick_pin = 1'h1;
    sleep_pin = 1'h1;
    repeat (12) @(negedge clock);
    check(16'({converter_on, phase_out}), 16'({1'h0, phase_offset_b}));
    freq_pick_pin = 1'h1;
    i_host.send(16'h0B00);
    moved(1'h1);
    reset_pin = 1'h1;
    repeat (6) @(negedge clock);
    check(16'(phase_out), 16'h0000);
    {freq_pick_pin, phase_pick_pin, reset_pin, sleep_pin} = 4'h0;
    i_host.send(16'h0880);
    moved(1'h0);
    i_host.send(16'h0900);
    check(16'(phase_out), 16'h0000);
    i_host.send(16'h0800);
    moved(1'h1);
    {freq_word_a, freq_word_b} = {28'h0100000, 28'h0000000};
    repeat (4) @(negedge clock);
    moved(1'h0);
    end_of_test();
  end
  // Watchdog well past the expected run length
  initial
  begin
    #500000;
    n_errors++;
    end_of_test();
  end
endmodule : tb_dds_control_word_fields
